// >>> common/sdc_pkg.sv
// package for the sigma-delta converter control block: register map, fields, reset values.
// assumes a 32-bit AXI4-Lite register bus; control words are 16 bits in the low half.
package sdc_pkg;
	localparam logic [3:0]  ADDR_CTRL_ONE   = 4'h0;
	localparam logic [3:0]  ADDR_CTRL_TWO   = 4'h4;
	localparam logic [3:0]  ADDR_CTRL_THREE = 4'h8;
	localparam logic [3:0]  ADDR_RESULT     = 4'hc;
	localparam logic [15:0] RST_CTRL        = 16'h0000;
	// writable bit masks; unimplemented and reserved positions read zero
	localparam logic [15:0] MASK_ONE        = 16'hb7d7;
	localparam logic [15:0] MASK_TWO        = 16'hf318;
	localparam logic [15:0] MASK_THREE      = 16'hff07;
	localparam int          POS_ENABLE      = 15;
	localparam int          POS_IDLE        = 13;
	localparam int          POS_MRST        = 12;
	localparam int          POS_RDY         = 0;
	localparam logic [1:0]  EV_GREATER      = 2'h0;
	localparam logic [1:0]  EV_LESS         = 2'h1;
	localparam logic [1:0]  EV_FIFTH        = 2'h2;
	localparam logic [1:0]  WM_WHEN_CLEAR   = 2'h0;
	localparam logic [1:0]  WM_ALWAYS       = 2'h1;
	localparam logic [2:0]  FIFTH_COUNT     = 3'h4;
	localparam int          SETTLE_RESULTS  = 3;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	typedef struct packed {
		logic [2:0]  gain;
		logic [1:0]  dither;
		logic        offset_measure;
		logic        neg_ref;
		logic        pos_ref;
		logic        bandwidth;
		logic        swap_en;
		logic [2:0]  channel;
		logic [10:0] osr;
		logic [6:0]  clk_div;
		logic        run;
		logic        analog_reset;
	} sdc_analog_cfg_t;
endpackage : sdc_pkg

// >>> rtl/sdc_top.sv
// control and result logic of a 16-bit sigma-delta converter, AXI4-Lite register slave.
// assumes the modulator delivers one filtered 32-bit word per sample_strobe on aclk.
// Overview of operation
// - converter runs only while the enable bit is set
// - halt_in_idle set stops operation whenever the device idles
// - module reset bit clears converter logic and holds analog section reset
// - gain codes 000..101 give 1..32, codes 11x reserved
// - offset measure bit samples internal offset instead of the input
// - reference selects pick external pins when 1, supplies when 0
// - bandwidth bit 1 gives double bandwidth, 0 normal
// - chopping field 11 enables, 00 disables, others reserved
// - event on greater, less, every fifth or every sample clock
// - result updates when ready clear, always, or never by policy
// - rounding to 24, 16, 8 bits or none
// - hardware sets ready after filter settling; software clears it
// - oversampling ratios from 16 up to 1024
// - output rate configurable from 976 sps up to 62.5 ksps
// - oversample code 000 is 1024 halving down to 110 is 16
// - channel codes 000..011 select inputs, 1xx reserved
// - divider codes 000..110 divide by 1..64, 111 reserved
`timescale 1ns/1ps
module sdc_top (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [3:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [3:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    device_idle,
	input  wire logic                    sample_strobe,
	input  wire logic [31:0]             sample_data,
	output sdc_pkg::sdc_analog_cfg_t     analog_cfg,
	output logic [31:0]                  conversion_result_pair,
	output logic                         converter_event
);
	import sdc_pkg::*;

	typedef struct packed {
		logic [15:0] ctrl_one;
		logic [15:0] ctrl_two;
		logic [15:0] ctrl_three;
		logic [31:0] result;
		logic [31:0] previous;
		logic [2:0]  fifth_cnt;
		logic [1:0]  settle_cnt;
		logic        have_prev;
		logic        aw_got;
		logic        w_got;
		logic [3:0]  aw_addr;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        idle_s1;
		logic        idle_s2;
		logic        evt;
		sdc_analog_cfg_t cfg;
	} sdc_state_t;

	sdc_state_t s_q;
	sdc_state_t s_d;

	logic        running;
	logic        evt_now;
	logic        do_write;
	logic        wr_clear_rdy;
	logic [31:0] rounded;
	logic [15:0] two_merged;

	// apply byte strobes to the low half-word only
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [15:0] mask);
		logic [15:0] m;
		m = {{8{strb[1]}}, {8{strb[0]}}};
		merge16 = ((old & ~m) | (data[15:0] & m)) & mask;
	endfunction : merge16

	// round to nearest at the chosen width, saturating so a carry cannot wrap the sign
	function automatic logic [31:0] round_to(input logic [31:0] v, input logic [1:0] sel);
		logic [32:0] sum;
		int          lsb;
		lsb = 0;
		unique case (sel)
			2'h1: lsb = 8;
			2'h2: lsb = 16;
			2'h3: lsb = 24;
			2'h0: lsb = 0;
		endcase
		if (lsb == 0) begin
			round_to = v;
		end else begin
			sum = {1'b0, v} + (33'h1 << (lsb - 1));
			if (!v[31] && sum[31]) begin
				sum = {1'b0, 32'h7fffffff};
			end
			round_to = sum[31:0] & ~((32'h1 << lsb) - 32'h1);
		end
	endfunction : round_to

	always_comb begin
		s_d = s_q;
		s_d.idle_s1 = device_idle;
		s_d.idle_s2 = s_q.idle_s1;
		s_d.evt = 1'b0;

		running = s_q.ctrl_one[POS_ENABLE] && !s_q.ctrl_one[POS_MRST]
			&& !(s_q.ctrl_one[POS_IDLE] && s_q.idle_s2);
		rounded = round_to(sample_data, s_q.ctrl_two[4:3]);

		evt_now = 1'b0;
		if (running && sample_strobe) begin
			unique case (s_q.ctrl_two[13:12])
				EV_GREATER: evt_now = s_q.have_prev && ($signed(rounded) > $signed(s_q.previous));
				EV_LESS:    evt_now = s_q.have_prev && ($signed(rounded) < $signed(s_q.previous));
				EV_FIFTH:   evt_now = (s_q.fifth_cnt == FIFTH_COUNT);
				default:    evt_now = 1'b1;
			endcase
			s_d.previous = rounded;
			s_d.have_prev = 1'b1;
			s_d.fifth_cnt = (s_q.fifth_cnt == FIFTH_COUNT) ? 3'h0 : s_q.fifth_cnt + 3'h1;
			if (s_q.settle_cnt != SETTLE_RESULTS[1:0]) begin
				s_d.settle_cnt = s_q.settle_cnt + 2'h1;
			end
		end
		s_d.evt = evt_now;

		if (evt_now && ((s_q.ctrl_two[9:8] == WM_ALWAYS)
			|| (s_q.ctrl_two[9:8] == WM_WHEN_CLEAR && !s_q.ctrl_two[POS_RDY]))) begin
			s_d.result = rounded;
		end

		// AXI4-Lite write: address and data taken in either order
		if (s_axi_awvalid && !s_q.aw_got && !s_q.bvalid) begin
			s_d.aw_got = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_got && !s_q.bvalid) begin
			s_d.w_got = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;
		wr_clear_rdy = 1'b0;
		two_merged = merge16(s_q.ctrl_two, s_q.w_data, s_q.w_strb, MASK_TWO);
		if (do_write) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = RESP_OKAY;
			unique case (s_q.aw_addr)
				ADDR_CTRL_ONE:   s_d.ctrl_one = merge16(s_q.ctrl_one, s_q.w_data, s_q.w_strb,
					MASK_ONE);
				ADDR_CTRL_TWO: begin
					// bit 0 is the ready flag, owned by the set/clear logic below
					s_d.ctrl_two[15:1] = two_merged[15:1];
					// writing zero clears ready; writing one leaves it
					wr_clear_rdy = s_q.w_strb[0] && !s_q.w_data[POS_RDY];
				end
				ADDR_CTRL_THREE: s_d.ctrl_three = merge16(s_q.ctrl_three, s_q.w_data,
					s_q.w_strb, MASK_THREE);
				default:         s_d.bresp = RESP_SLVERR;
			endcase
			if (s_q.aw_addr == ADDR_RESULT) begin
				s_d.bresp = RESP_OKAY;
			end
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end

		// set beats clear when both land together
		if (wr_clear_rdy) begin
			s_d.ctrl_two[POS_RDY] = 1'b0;
		end
		if (running && sample_strobe && s_q.settle_cnt == SETTLE_RESULTS[1:0]) begin
			s_d.ctrl_two[POS_RDY] = 1'b1;
		end

		// AXI4-Lite read
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_CTRL_ONE:   s_d.rdata = {16'h0000, s_q.ctrl_one};
				ADDR_CTRL_TWO:   s_d.rdata = {16'h0000, s_q.ctrl_two};
				ADDR_CTRL_THREE: s_d.rdata = {16'h0000, s_q.ctrl_three};
				ADDR_RESULT:     s_d.rdata = s_q.result;
				default: begin
					s_d.rdata = 32'h00000000;
					s_d.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end

		// module reset clears the sample history and counters but keeps the control words and the result
		if (s_q.ctrl_one[POS_MRST] || !s_q.ctrl_one[POS_ENABLE]) begin
			s_d.have_prev = 1'b0;
			s_d.fifth_cnt = 3'h0;
			s_d.settle_cnt = 2'h0;
			s_d.previous = 32'h00000000;
		end

		s_d.cfg.gain = (s_q.ctrl_one[10:9] == 2'h3) ? 3'h0 : s_q.ctrl_one[10:8];
		s_d.cfg.dither = s_q.ctrl_one[7:6];
		s_d.cfg.offset_measure = s_q.ctrl_one[4];
		s_d.cfg.neg_ref = s_q.ctrl_one[2];
		s_d.cfg.pos_ref = s_q.ctrl_one[1];
		s_d.cfg.bandwidth = s_q.ctrl_one[0];
		// reserved chopping codes treated as off
		s_d.cfg.swap_en = (s_q.ctrl_two[15:14] == 2'h3);
		s_d.cfg.channel = s_q.ctrl_three[2] ? 3'h0 : s_q.ctrl_three[2:0];
		// reserved code falls back to ratio 16
		s_d.cfg.osr = (s_q.ctrl_three[12:10] == 3'h7) ? 11'd16
			: (11'd1024 >> s_q.ctrl_three[12:10]);
		// reserved code falls back to divide by 64
		s_d.cfg.clk_div = (s_q.ctrl_three[15:13] == 3'h7) ? 7'd64
			: (7'd1 << s_q.ctrl_three[15:13]);
		s_d.cfg.run = running;
		s_d.cfg.analog_reset = s_q.ctrl_one[POS_MRST] || !s_q.ctrl_one[POS_ENABLE];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.ctrl_one <= RST_CTRL;
			s_q.ctrl_two <= RST_CTRL;
			s_q.ctrl_three <= RST_CTRL;
			s_q.cfg.analog_reset <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
	assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign analog_cfg = s_q.cfg;
	assign conversion_result_pair = s_q.result;
	assign converter_event = s_q.evt;
endmodule : sdc_top

// >>> dv/sdc_modulator.sv
// behavioural modulator and decimation filter at the converter's far side.
// assumes the bench raises fire for one cycle per wanted filtered result.
`timescale 1ns/1ps
module sdc_modulator (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        fire,
	input  wire logic [31:0] fval,
	output logic             sample_strobe,
	output logic [31:0]      sample_data
);
	// data toggles between strobes so a stale word is never taken for a fresh one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sample_strobe <= 1'b0;
			sample_data   <= 32'h0000_0000;
		end else begin
			sample_strobe <= fire;
			sample_data   <= fire ? fval : ~sample_data;
		end
	end
endmodule : sdc_modulator

// >>> dv/sdc_monitor.sv
// checker for the converter control block: bus answers and data path timing.
// assumes it is bound into sdc_top and sees its ports only.
`timescale 1ns/1ps
module sdc_monitor (
	input wire logic                     aclk,
	input wire logic                     aresetn,
	input wire logic                     s_axi_awvalid,
	input wire logic                     s_axi_awready,
	input wire logic                     s_axi_wvalid,
	input wire logic                     s_axi_wready,
	input wire logic                     s_axi_bvalid,
	input wire logic                     s_axi_bready,
	input wire logic [1:0]               s_axi_bresp,
	input wire logic                     s_axi_arvalid,
	input wire logic                     s_axi_arready,
	input wire logic                     s_axi_rvalid,
	input wire logic                     s_axi_rready,
	input wire logic [31:0]              s_axi_rdata,
	input wire logic                     sample_strobe,
	input wire sdc_pkg::sdc_analog_cfg_t analog_cfg,
	input wire logic                     converter_event
);
	import sdc_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed early");
	AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_B_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid) else $error("write response late");
	AST_EV_CAUSE: assert property (converter_event |-> $past(sample_strobe))
		else $error("event without a sample");
	// event and run flag leave the same edge, so they must agree in the same cycle
	AST_EV_RUN: assert property (converter_event |-> analog_cfg.run)
		else $error("event while stopped");
	AST_RUN_RST: assert property (!(analog_cfg.run && analog_cfg.analog_reset))
		else $error("running while held in reset");
	AST_OSR: assert property ($past(aresetn) |-> analog_cfg.osr inside {[16:1024]})
		else $error("ratio out of range");
	AST_DIV: assert property ($past(aresetn) |->
		analog_cfg.clk_div inside {1, 2, 4, 8, 16, 32, 64})
		else $error("divider out of range");
	cover property (converter_event);
	cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
	cover property (s_axi_rvalid && s_axi_rready);
endmodule : sdc_monitor
bind sdc_top sdc_monitor u_sdc_monitor (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .sample_strobe, .analog_cfg,
	.converter_event
);

// >>> dv/sdc_top_bench.sv
// self-checking bench for the converter control block over AXI4-Lite.
// assumes sdc_modulator stands in for the analog side and sdc_monitor is bound in.
`timescale 1ns/1ps
module sdc_top_bench;
	import sdc_pkg::*;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, device_idle = 0, fire = 0;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
	logic [31:0] s_axi_wdata = 0, fval = 0, sample_data, s_axi_rdata, conversion_result_pair;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic sample_strobe, converter_event;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	sdc_analog_cfg_t analog_cfg;
	int n_mismatch = 0, num_checks = 0, n_ev = 0;
	sdc_top u_sdc_top (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .device_idle, .sample_strobe,
		.sample_data, .analog_cfg, .conversion_result_pair, .converter_event
	);
	sdc_modulator u_sdc_modulator (.aclk, .aresetn, .fire, .fval, .sample_strobe, .sample_data);
	initial begin
		forever #12.5 aclk = ~aclk;
	end
	// counted mid-cycle where the one-cycle pulse is settled; tasks work on differences
	always @(negedge aclk) if (converter_event === 1'b1) n_ev <= n_ev + 1;
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// readies are sampled at the falling edge, where they are settled for the next rising edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] er = RESP_OKAY);
		logic aw, w, b;
		logic [1:0] r;
		int t;
		t = 0;
		s_axi_awaddr <= a; s_axi_wdata <= {16'h0000, d}; s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			aw = s_axi_awready === 1'b1; w = s_axi_wready === 1'b1;
			b = s_axi_bvalid === 1'b1; r = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			t++;
		end while (!b && t < 50);
		s_axi_bready <= 1'b0;
		if (!b) begin n_mismatch++; stop_test; end
		chk("bresp", 32'(er), 32'(r));
		repeat (2) @(posedge aclk);
	endtask : wr
	task automatic rc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
		logic k, v;
		logic [31:0] d;
		logic [1:0] r;
		int t;
		t = 0;
		s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			k = s_axi_arready === 1'b1; v = s_axi_rvalid === 1'b1;
			d = s_axi_rdata; r = s_axi_rresp;
			@(posedge aclk);
			if (k) s_axi_arvalid <= 1'b0;
			t++;
		end while (!v && t < 50);
		s_axi_rready <= 1'b0;
		if (!v) begin n_mismatch++; stop_test; end
		chk("rdata", e, d);
		chk("rresp", 32'(er), 32'(r));
		@(posedge aclk);
	endtask : rc
	task automatic smp(input logic [31:0] v);
		@(posedge aclk);
		fire <= 1'b1; fval <= v;
		@(posedge aclk);
		fire <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask : smp
	task automatic t_fields;
		rc(ADDR_CTRL_ONE, 0, RESP_OKAY);
		rc(ADDR_CTRL_TWO, 0, RESP_OKAY);
		rc(4'h2, 0, RESP_SLVERR);
		wr(ADDR_CTRL_ONE, 16'hf7ff);
		rc(ADDR_CTRL_ONE, 32'(MASK_ONE & 16'hf7ff), RESP_OKAY);
		chk("misc", 6'h3f, {analog_cfg.dither, analog_cfg.offset_measure, analog_cfg.neg_ref,
			analog_cfg.pos_ref, analog_cfg.bandwidth});
		wr(ADDR_CTRL_ONE, 16'h0045);
		chk("misc", 6'h15, {analog_cfg.dither, analog_cfg.offset_measure, analog_cfg.neg_ref,
			analog_cfg.pos_ref, analog_cfg.bandwidth});
		wr(ADDR_CTRL_TWO, 16'hfffe);
		rc(ADDR_CTRL_TWO, 32'(MASK_TWO & 16'hfffe), RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_CTRL_ONE, 16'(i << 8));
			chk("gain", i < 6 ? i : 0, analog_cfg.gain);
			wr(ADDR_CTRL_TWO, 16'((i % 4) << 14));
			chk("input_swap_enable", (i % 4) == 3, analog_cfg.swap_en);
			wr(ADDR_CTRL_THREE, 16'((i << 13) | (i << 10) | i));
			chk("chan", i < 4 ? i : 0, analog_cfg.channel);
			chk("osr", i == 7 ? 16 : 1024 >> i, analog_cfg.osr);
			chk("div", i == 7 ? 64 : 1 << i, analog_cfg.clk_div);
		end
		rc(ADDR_CTRL_THREE, 32'(MASK_THREE & 16'hfc07), RESP_OKAY);
		wr(ADDR_RESULT, 16'hffff);
		rc(ADDR_RESULT, 0, RESP_OKAY);
		wr(4'h2, 16'hffff, RESP_SLVERR);
	endtask : t_fields
	task automatic t_events;
		logic [1:0] cd [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
		int ns [4] = '{6, 10, 4, 4};
		int ex [4] = '{6, 2, 3, 3};
		int b0;
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_CTRL_ONE, 16'h0000);
			wr(ADDR_CTRL_TWO, 16'h0100 | 16'(cd[m]) << 12);
			wr(ADDR_CTRL_ONE, 16'h8000);
			b0 = n_ev;
			for (int i = 0; i < ns[m]; i++) smp(m == 3 ? 32'(100 - i) : 32'(i + 5));
			chk("events", ex[m], n_ev - b0);
		end
		chk("result", 97, conversion_result_pair);
		rc(ADDR_CTRL_TWO, 32'h0000_1101, RESP_OKAY);
		wr(ADDR_CTRL_TWO, 16'h1100);
		rc(ADDR_CTRL_TWO, 32'h0000_1100, RESP_OKAY);
	endtask : t_events
	task automatic t_policy;
		logic [31:0] rx [4] = '{32'h1234_8080, 32'h1234_8100, 32'h1235_0000, 32'h1200_0000};
		wr(ADDR_CTRL_ONE, 16'h0000);
		wr(ADDR_CTRL_TWO, 16'h3000);
		wr(ADDR_CTRL_ONE, 16'h8000);
		for (int i = 1; i <= 5; i++) smp(32'(i));
		chk("result", 4, conversion_result_pair);
		wr(ADDR_CTRL_TWO, 16'h3200);
		smp(32'h0000_004d);
		chk("result", 4, conversion_result_pair);
		for (int r = 0; r < 4; r++) begin
			wr(ADDR_CTRL_TWO, 16'h3100 | 16'(r << 3));
			smp(32'h1234_8080);
			rc(ADDR_RESULT, rx[r], RESP_OKAY);
		end
	endtask : t_policy
	task automatic t_idle;
		logic [15:0] cv [5] = '{16'ha000, 16'ha000, 16'h8000, 16'h0000, 16'h9000};
		logic id [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
		int ex [5] = '{0, 1, 1, 0, 0};
		int b0;
		for (int k = 0; k < 5; k++) begin
			wr(ADDR_CTRL_ONE, cv[k]);
			device_idle <= id[k];
			repeat (4) @(posedge aclk);
			b0 = n_ev;
			smp(32'h0000_0001);
			chk("events", ex[k], n_ev - b0);
		end
		chk("areset", 1, analog_cfg.analog_reset);
	endtask : t_idle
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_fields;
		t_events;
		t_policy;
		t_idle;
		stop_test;
	end
endmodule : sdc_top_bench
